/* File: common/sync_slave_pkg.sv */
package sync_slave_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets (word aligned)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PERIPH_FLAGS = 8'h04;
  localparam logic [7:0] OFS_PERIPH_ENABLES = 8'h08;
  localparam logic [7:0] OFS_PERIPH_PRIORITY = 8'h0C;
  localparam logic [7:0] OFS_RECEIVE_STATUS = 8'h10;
  localparam logic [7:0] OFS_TRANSMIT_HOLDING = 8'h14;
  localparam logic [7:0] OFS_TRANSMIT_STATUS = 8'h18;
  localparam logic [7:0] OFS_BAUD_CONTROL = 8'h1C;
  localparam logic [7:0] OFS_BAUD_DIV_HIGH = 8'h20;
  localparam logic [7:0] OFS_BAUD_DIV_LOW = 8'h24;
  localparam logic [7:0] OFS_PORT_G_LATCH = 8'h28;
  localparam logic [7:0] OFS_RECEIVE_HOLDING = 8'h2C;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h30;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_GLOBAL_IE = 7;
  localparam int BIT_PERIPH_IE = 6;
  localparam int BIT_RX_FLAG = 5;
  localparam int BIT_TX_FLAG = 4;
  localparam int BIT_SERIAL_EN = 7;
  localparam int BIT_NINE_RX_EN = 6;
  localparam int BIT_SINGLE_RX = 5;
  localparam int BIT_CONT_RX = 4;
  localparam int BIT_FRAME_ERR = 2;
  localparam int BIT_OVERRUN = 1;
  localparam int BIT_RX_NINTH = 0;
  localparam int BIT_CLK_MASTER = 7;
  localparam int BIT_NINE_TX_EN = 6;
  localparam int BIT_TX_EN = 5;
  localparam int BIT_SYNC_MODE = 4;
  localparam int BIT_SHIFT_EMPTY = 1;
  localparam int BIT_TX_NINTH = 0;
  localparam int BIT_SLEEP = 0;
  localparam int BIT_IDLE = 1;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TX_STATUS = 8'h02;

  // ----------------------------------------------------------------------
  // Bus constants and serial word bit counts
  // ----------------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [3:0] BIT_COUNT_8 = 4'h8;
  localparam logic [3:0] BIT_COUNT_9 = 4'h9;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } ahb_req_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_RELOAD = 2'b10
  } tx_state_t;

endpackage

/* File: hw/sync_slave_serial_port.sv */
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ns
module sync_slave_serial_port
  import sync_slave_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire sync_slave_pkg::ahb_req_t ahb_req,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic shift_clock_pin,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output logic interrupt_request,
  output logic vector_request,
  output logic wake_request
);
  import sync_slave_pkg::*;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0] interrupt_control_reg;
  logic [7:0] periph_enables_reg;
  logic [7:0] periph_priority_reg;
  logic [7:0] receive_status_reg;
  logic [7:0] transmit_status_reg;
  logic [7:0] baud_control_reg;
  logic [7:0] baud_div_high_reg;
  logic [7:0] baud_div_low_reg;
  logic [7:0] port_g_latch_reg;
  logic [7:0] power_control_reg;
  logic [7:0] transmit_holding_reg;
  logic [7:0] receive_holding_reg;
  logic transmit_holding_full_reg;
  logic transmit_buffer_empty_flag_reg;
  logic receive_complete_flag_reg;
  logic overrun_error_flag_reg;
  logic received_ninth_bit_reg;

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic dphase_reg;
  logic dwrite_reg;
  logic [7:0] daddr_reg;
  logic wr_stb;
  logic rd_stb;

  assign wr_stb = clk_en & dphase_reg & dwrite_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dphase_reg <= 1'b0;
      dwrite_reg <= 1'b0;
      daddr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      dphase_reg <= ahb_req.hsel & ahb_req.hready &
                    (ahb_req.htrans == HTRANS_NONSEQ);
      dwrite_reg <= ahb_req.hwrite;
      daddr_reg <= ahb_req.haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign rd_stb = clk_en & ahb_req.hsel & ahb_req.hready &
                  (ahb_req.htrans == HTRANS_NONSEQ) & ~ahb_req.hwrite;

  logic serial_enable;
  logic cont_rx;
  logic low_power;
  assign serial_enable = receive_status_reg[BIT_SERIAL_EN];
  assign cont_rx = receive_status_reg[BIT_CONT_RX];
  assign low_power = power_control_reg[BIT_SLEEP] |
                     power_control_reg[BIT_IDLE];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interrupt_control_reg <= RST_ZERO;
      periph_enables_reg <= RST_ZERO;
      periph_priority_reg <= RST_ZERO;
      receive_status_reg <= RST_ZERO;
      transmit_status_reg <= RST_ZERO;
      baud_control_reg <= RST_ZERO;
      baud_div_high_reg <= RST_ZERO;
      baud_div_low_reg <= RST_ZERO;
      port_g_latch_reg <= RST_ZERO;
      power_control_reg <= RST_ZERO;
    end else if (wr_stb) begin
      if (hit(daddr_reg, OFS_INTERRUPT_CONTROL)) begin
        interrupt_control_reg <= hwdata[7:0];
      end else if (hit(daddr_reg, OFS_PERIPH_ENABLES)) begin
        periph_enables_reg <= hwdata[7:0];
      end else if (hit(daddr_reg, OFS_PERIPH_PRIORITY)) begin
        periph_priority_reg <= hwdata[7:0];
      end else if (hit(daddr_reg, OFS_RECEIVE_STATUS)) begin
        receive_status_reg <= {hwdata[7:3], 3'h0};
      end else if (hit(daddr_reg, OFS_TRANSMIT_STATUS)) begin
        transmit_status_reg <= {hwdata[7:2], 1'b0, hwdata[0]};
      end else if (hit(daddr_reg, OFS_BAUD_CONTROL)) begin
        baud_control_reg <= hwdata[7:0];
      end else if (hit(daddr_reg, OFS_BAUD_DIV_HIGH)) begin
        baud_div_high_reg <= hwdata[7:0];
      end else if (hit(daddr_reg, OFS_BAUD_DIV_LOW)) begin
        baud_div_low_reg <= hwdata[7:0];
      end else if (hit(daddr_reg, OFS_PORT_G_LATCH)) begin
        port_g_latch_reg <= hwdata[7:0];
      end else if (hit(daddr_reg, OFS_POWER_CONTROL)) begin
        power_control_reg <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Shift clock synchroniser and edge detect
  // ----------------------------------------------------------------------
  logic [1:0] sck_sync_reg;
  logic [1:0] sdi_sync_reg;
  logic sck_last_reg;
  logic sck_rise;
  logic sck_fall;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sck_sync_reg <= 2'b00;
      sdi_sync_reg <= 2'b00;
      sck_last_reg <= 1'b0;
    end else if (clk_en) begin
      sck_sync_reg <= {sck_sync_reg[0], shift_clock_pin};
      sdi_sync_reg <= {sdi_sync_reg[0], serial_data_pin_in};
      sck_last_reg <= sck_sync_reg[1];
    end
  end

  assign sck_rise = clk_en & sck_sync_reg[1] & ~sck_last_reg;
  assign sck_fall = clk_en & ~sck_sync_reg[1] & sck_last_reg;

  // ----------------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------------
  // Continuous receive enable takes the data line over, as in master mode.
  logic tx_allowed;
  assign tx_allowed = serial_enable & transmit_status_reg[BIT_TX_EN] &
                      ~cont_rx;

  logic tx_write;
  assign tx_write = wr_stb & hit(daddr_reg, OFS_TRANSMIT_HOLDING);

  tx_state_t tx_state_reg;
  logic [8:0] tx_shift_reg;
  logic [3:0] tx_count_reg;
  logic [3:0] tx_len;
  assign tx_len = transmit_status_reg[BIT_NINE_TX_EN] ? BIT_COUNT_9
                                                  : BIT_COUNT_8;

  // The state machine runs the same in sleep; sleep only gates the core.
  always_ff @(posedge clock) begin
    if (!rst_n || !serial_enable) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 9'h000;
      tx_count_reg <= 4'h0;
      transmit_holding_reg <= RST_ZERO;
      transmit_holding_full_reg <= 1'b0;
      transmit_buffer_empty_flag_reg <= 1'b1;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe <= 1'b0;
    end else if (clk_en) begin
      serial_data_pin_oe <= tx_allowed & (tx_state_reg == TX_SHIFT);
      if (tx_write) begin
        transmit_holding_reg <= hwdata[7:0];
        transmit_holding_full_reg <= 1'b1;
        transmit_buffer_empty_flag_reg <= 1'b0;
      end
      case (tx_state_reg)
        TX_IDLE: begin
          if (transmit_holding_full_reg && tx_allowed) begin
            tx_shift_reg <= {transmit_status_reg[BIT_TX_NINTH],
                             transmit_holding_reg};
            tx_count_reg <= tx_len;
            serial_data_pin_out <= transmit_holding_reg[0];
            if (!tx_write) begin
              transmit_holding_full_reg <= 1'b0;
              transmit_buffer_empty_flag_reg <= 1'b1;
            end
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          // Holding word waits and the flag stays low while shifting.
          if (sck_rise) begin
            serial_data_pin_out <= tx_shift_reg[1];
            tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
            tx_count_reg <= tx_count_reg - 4'h1;
            if (tx_count_reg == 4'h1) begin
              tx_state_reg <= TX_RELOAD;
            end
          end
        end
        TX_RELOAD: begin
          // Back to idle; the next word is moved in there in the cycle the empty flag rises.
          tx_state_reg <= TX_IDLE;
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------------
  logic [8:0] rx_shift_reg;
  logic [3:0] rx_count_reg;
  logic rx_done;
  logic rx_len9;
  logic rd_holding;
  assign rx_len9 = receive_status_reg[BIT_NINE_RX_EN];
  assign rd_holding = rd_stb & hit(ahb_req.haddr[7:0], OFS_RECEIVE_HOLDING);
  assign rx_done = sck_fall & serial_enable & cont_rx &
                   (rx_count_reg == (rx_len9 ? BIT_COUNT_9 - 4'h1
                                             : BIT_COUNT_8 - 4'h1));

  // Single receive enable has no effect here: slave mode ignores it.
  always_ff @(posedge clock) begin
    if (!rst_n || !serial_enable || !cont_rx) begin
      rx_shift_reg <= 9'h000;
      rx_count_reg <= 4'h0;
    end else if (sck_fall) begin
      rx_shift_reg <= {sdi_sync_reg[1], rx_shift_reg[8:1]};
      rx_count_reg <= rx_done ? 4'h0 : rx_count_reg + 4'h1;
    end
  end

  logic [8:0] rx_word;
  assign rx_word = rx_len9 ? {sdi_sync_reg[1], rx_shift_reg[8:1]}
                           : {1'b0, sdi_sync_reg[1], rx_shift_reg[8:2]};

  always_ff @(posedge clock) begin
    if (!rst_n || !serial_enable) begin
      receive_holding_reg <= RST_ZERO;
      received_ninth_bit_reg <= 1'b0;
      receive_complete_flag_reg <= 1'b0;
      overrun_error_flag_reg <= 1'b0;
    end else if (clk_en) begin
      if (!cont_rx) begin
        overrun_error_flag_reg <= 1'b0;
      end else if (rx_done && receive_complete_flag_reg && !rd_holding) begin
        overrun_error_flag_reg <= 1'b1;
      end
      if (rx_done && !(receive_complete_flag_reg && !rd_holding)) begin
        receive_holding_reg <= rx_word[7:0];
        received_ninth_bit_reg <= rx_word[8];
        receive_complete_flag_reg <= 1'b1;
      end else if (rd_holding) begin
        receive_complete_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt, wake and read data
  // ----------------------------------------------------------------------
  logic [7:0] flags_view;
  logic tx_irq;
  logic rx_irq;
  assign flags_view = {2'b00, receive_complete_flag_reg,
                       transmit_buffer_empty_flag_reg, 4'h0};
  assign tx_irq = transmit_buffer_empty_flag_reg &
                  periph_enables_reg[BIT_TX_FLAG];
  assign rx_irq = receive_complete_flag_reg &
                  periph_enables_reg[BIT_RX_FLAG];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interrupt_request <= 1'b0;
      vector_request <= 1'b0;
      wake_request <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      interrupt_request <= tx_irq | rx_irq;
      wake_request <= low_power & (tx_irq | rx_irq);
      vector_request <= (tx_irq | rx_irq) &
                        interrupt_control_reg[BIT_GLOBAL_IE] &
                        interrupt_control_reg[BIT_PERIPH_IE];
      if (rd_stb) begin
        if (hit(ahb_req.haddr[7:0], OFS_INTERRUPT_CONTROL)) begin
          hrdata <= {24'h0, interrupt_control_reg};
        end else if (hit(ahb_req.haddr[7:0], OFS_PERIPH_FLAGS)) begin
          hrdata <= {24'h0, flags_view};
        end else if (hit(ahb_req.haddr[7:0], OFS_PERIPH_ENABLES)) begin
          hrdata <= {24'h0, periph_enables_reg};
        end else if (hit(ahb_req.haddr[7:0], OFS_PERIPH_PRIORITY)) begin
          hrdata <= {24'h0, periph_priority_reg};
        end else if (hit(ahb_req.haddr[7:0], OFS_RECEIVE_STATUS)) begin
          hrdata <= {24'h0, receive_status_reg[7:3], 1'b0,
                     overrun_error_flag_reg, received_ninth_bit_reg};
        end else if (hit(ahb_req.haddr[7:0], OFS_TRANSMIT_STATUS)) begin
          hrdata <= {24'h0, transmit_status_reg[7:2],
                     tx_state_reg == TX_IDLE, transmit_status_reg[0]};
        end else if (hit(ahb_req.haddr[7:0], OFS_BAUD_CONTROL)) begin
          hrdata <= {24'h0, baud_control_reg};
        end else if (hit(ahb_req.haddr[7:0], OFS_BAUD_DIV_HIGH)) begin
          hrdata <= {24'h0, baud_div_high_reg};
        end else if (hit(ahb_req.haddr[7:0], OFS_BAUD_DIV_LOW)) begin
          hrdata <= {24'h0, baud_div_low_reg};
        end else if (hit(ahb_req.haddr[7:0], OFS_PORT_G_LATCH)) begin
          hrdata <= {24'h0, port_g_latch_reg};
        end else if (hit(ahb_req.haddr[7:0], OFS_RECEIVE_HOLDING)) begin
          hrdata <= {24'h0, receive_holding_reg};
        end else if (hit(ahb_req.haddr[7:0], OFS_POWER_CONTROL)) begin
          hrdata <= {24'h0, power_control_reg};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule // sync_slave_serial_port

/* File: tb/sync_master_model.sv */
`timescale 1ns/1ns
module sync_master_model (
  output logic shift_clock_pin,
  output logic data_drive,
  input wire logic data_line
);
  initial begin
    shift_clock_pin = 1'b0;
    data_drive = 1'b0;
  end

  // Clock stands low between frames; data moves mid-high so it is
  // settled long before the falling edge the port samples on
  task automatic frame(input int n, input logic drv, input logic [8:0] w,
                       output logic [8:0] r);
    r = 9'h000;
    #37;
    for (int i = 0; i < n; i++) begin
      #400;
      r[i] = data_line;
      shift_clock_pin = 1'b1;
      #200;
      if (drv) data_drive = w[i];
      #200;
      shift_clock_pin = 1'b0;
    end
    #400;
    data_drive = ~data_drive;
  endtask
endmodule // sync_master_model

/* File: tb/sync_slave_serial_port_sva.sv */
`timescale 1ns/1ns
module sync_slave_serial_port_sva
  import sync_slave_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire sync_slave_pkg::ahb_req_t ahb_req,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic shift_clock_pin,
  input wire logic serial_data_pin_in,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe,
  input wire logic interrupt_request,
  input wire logic vector_request,
  input wire logic wake_request
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [2:0] sclk_sync_reg;
  logic [3:0] rise_count_reg;
  logic tx_write_reg;
  wire logic bus_take = ahb_req.hsel && ahb_req.hready && clk_en &&
    ahb_req.htrans == HTRANS_NONSEQ;
  // Same two-flop depth as the port, so rises line up with its shifts
  wire logic sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];

  always_ff @(posedge clock) begin
    sclk_sync_reg <= {sclk_sync_reg[1:0], shift_clock_pin};
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !serial_data_pin_oe) begin
      rise_count_reg <= 4'h0;
    end else if (sclk_rise) begin
      rise_count_reg <= rise_count_reg + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    tx_write_reg <= rst_n && bus_take && ahb_req.hwrite &&
      ahb_req.haddr[7:0] == OFS_TRANSMIT_HOLDING;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response is not OKAY");
  chk_ready_zero_wait: assert property ($past(bus_take) |-> hreadyout)
    else $error("bus ready low after a taken request");
  chk_read_upper_zero: assert property (
    $past(bus_take && !ahb_req.hwrite) |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bytes not zero");
  chk_vector_needs_irq: assert property (
    vector_request |-> interrupt_request)
    else $error("vector request without interrupt");
  chk_wake_needs_irq: assert property (
    wake_request |-> interrupt_request)
    else $error("wake request without interrupt");
  chk_out_on_rise: assert property (
    serial_data_pin_oe && $past(serial_data_pin_oe) &&
    $changed(serial_data_pin_out) |->
    $past(shift_clock_pin, 2) || $past(shift_clock_pin, 3))
    else $error("data out moved without a shift clock rise");
  chk_tx_start_cause: assert property (
    $rose(serial_data_pin_oe) |-> $past(tx_write_reg, 1) ||
    $past(tx_write_reg, 2) || $past(tx_write_reg, 3) ||
    $past(serial_data_pin_oe, 2) || $past(serial_data_pin_oe, 3))
    else $error("transmit started without a holding write");
  chk_word_length: assert property (
    $fell(serial_data_pin_oe) |->
    rise_count_reg == BIT_COUNT_8 || rise_count_reg == BIT_COUNT_9)
    else $error("word shifted out with wrong bit count");
endmodule // sync_slave_serial_port_sva

bind sync_slave_serial_port sync_slave_serial_port_sva checker_inst (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .ahb_req(ahb_req),
  .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .shift_clock_pin(shift_clock_pin),
  .serial_data_pin_in(serial_data_pin_in),
  .serial_data_pin_out(serial_data_pin_out),
  .serial_data_pin_oe(serial_data_pin_oe),
  .interrupt_request(interrupt_request),
  .vector_request(vector_request), .wake_request(wake_request));

/* File: tb/sync_slave_serial_port_tb.sv */
`timescale 1ns/1ns
module sync_slave_serial_port_tb;
  import sync_slave_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0, hsel = 1'b0;
  logic hreadyout, hresp, sclk, m_data, line, d_out, d_oe, irq, vec, wake;
  int n_errors = 0, total_checks = 0, cycles = 0;
  ahb_req_t req;
  assign req = '{haddr, htrans, hwrite, 3'h2, hsel, hreadyout};
  // Released line shows the partner's inverted last value
  assign line = d_oe ? d_out : m_data;

  always #50 clock = ~clock;

  sync_slave_serial_port uut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .ahb_req(req), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .shift_clock_pin(sclk), .serial_data_pin_in(line),
    .serial_data_pin_out(d_out), .serial_data_pin_oe(d_oe),
    .interrupt_request(irq), .vector_request(vec), .wake_request(wake));

  sync_master_model partner (.shift_clock_pin(sclk), .data_drive(m_data),
    .data_line(line));

  task automatic summarize();
    $display("Mismatches: %0d, checks: %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [8:0] g, input logic [8:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    @(posedge clock);
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsel <= 1'b1;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    check({1'b0, r}, {1'b0, e});
  endtask

  task automatic pins(input logic [2:0] e);
    @(negedge clock);
    check({6'h0, irq, wake, vec}, {6'h0, e});
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 200) begin
      @(posedge clock);
      k++;
    end
  endtask

  task automatic xfer(input int n, input logic drv, input logic [8:0] w,
                      input logic [8:0] e);
    logic [8:0] g;
    partner.frame(n, drv, w, g);
    if (!drv) check(g, e);
  endtask

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      summarize();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(OFS_TRANSMIT_STATUS, RST_TX_STATUS);
    rd(OFS_PERIPH_FLAGS, 8'h10);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h00);
    // Clock enable low: a write in that window must not land
    clk_en <= 1'b0;
    wr(OFS_PORT_G_LATCH, 8'h5A);
    clk_en <= 1'b1;
    rd(OFS_PORT_G_LATCH, 8'h00);
    wr(OFS_RECEIVE_STATUS, 8'h80);
    wr(OFS_TRANSMIT_STATUS, 8'h30);
    wr(OFS_PERIPH_ENABLES, 8'h10);
    wr(OFS_INTERRUPT_CONTROL, 8'hC0);
    wr(OFS_TRANSMIT_HOLDING, 8'hA5);
    wr(OFS_TRANSMIT_HOLDING, 8'h3C);
    wr(OFS_POWER_CONTROL, 8'h01);
    rd(OFS_PERIPH_FLAGS, 8'h00);
    pins(3'b000);
    xfer(8, 1'b0, 9'h000, 9'h0A5);
    wait_irq();
    pins(3'b111);
    rd(OFS_PERIPH_FLAGS, 8'h10);
    xfer(8, 1'b0, 9'h000, 9'h03C);
    wr(OFS_POWER_CONTROL, 8'h00);
    rd(OFS_TRANSMIT_STATUS, 8'h32);
    wr(OFS_TRANSMIT_STATUS, 8'h71);
    wr(OFS_TRANSMIT_HOLDING, 8'h5A);
    xfer(9, 1'b0, 9'h000, 9'h15A);
    wr(OFS_TRANSMIT_STATUS, 8'h10);
    wr(OFS_PERIPH_ENABLES, 8'h20);
    wr(OFS_RECEIVE_STATUS, 8'hF0);
    wr(OFS_POWER_CONTROL, 8'h02);
    pins(3'b000);
    xfer(9, 1'b1, 9'h1C3, 9'h000);
    wait_irq();
    pins(3'b111);
    rd(OFS_PERIPH_FLAGS, 8'h30);
    rd(OFS_RECEIVE_STATUS, 8'hF1);
    rd(OFS_RECEIVE_HOLDING, 8'hC3);
    rd(OFS_PERIPH_FLAGS, 8'h10);
    xfer(9, 1'b1, 9'h0AA, 9'h000);
    xfer(9, 1'b1, 9'h155, 9'h000);
    repeat (4) @(posedge clock);
    rd(OFS_RECEIVE_STATUS, 8'hF2);
    wr(OFS_RECEIVE_STATUS, 8'hE0);
    rd(OFS_RECEIVE_STATUS, 8'hE0);
    rd(OFS_RECEIVE_HOLDING, 8'hAA);
    // Second reset in mid-run brings the control registers back to zero
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(OFS_RECEIVE_STATUS, 8'h00);
    rd(OFS_PERIPH_ENABLES, 8'h00);
    pins(3'b000);
    summarize();
  end
endmodule // sync_slave_serial_port_tb
